/* src/rtcts_pkg.sv */
// package for the timebase source control block: register map, field
// positions, reset values, timing figures and the state record.
// assumes a 250 MHz system clock and a byte-addressed register port.
package rtcts_pkg;

  // ==========================================================================
  // register map (index, byte address is four times the index)
  localparam logic [7:0] RTCTS_IDX_CTRL = 8'h04;
  localparam logic [7:0] RTCTS_IDX_OSC_CTL = 8'h05;
  localparam logic [7:0] RTCTS_IDX_OSC_CFG = 8'h06;
  localparam logic [7:0] RTCTS_IDX_ROUTE = 8'h20;
  localparam logic [7:0] RTCTS_ADDR_CTRL = 8'(RTCTS_IDX_CTRL * 4);
  localparam logic [7:0] RTCTS_ADDR_OSC_CTL = 8'(RTCTS_IDX_OSC_CTL * 4);
  localparam logic [7:0] RTCTS_ADDR_OSC_CFG = 8'(RTCTS_IDX_OSC_CFG * 4);
  localparam logic [7:0] RTCTS_ADDR_ROUTE = 8'(RTCTS_IDX_ROUTE * 4);

  // ==========================================================================
  // field positions
  localparam int RTCTS_B_POWER = 7;
  localparam int RTCTS_B_MCD_EN = 6;
  localparam int RTCTS_B_FAIL = 5;
  localparam int RTCTS_B_OSC_CRYSTAL_SELECT = 6;
  localparam int RTCTS_B_BIAS2 = 5;
  localparam int RTCTS_B_CLOCK_VALID_FLAG = 4;
  localparam int RTCTS_B_LFO_EN = 3;
  localparam int RTCTS_B_AGC = 2;
  localparam int RTCTS_B_AUTOSTEP = 7;
  localparam int RTCTS_B_CAP_RDY = 6;
  localparam int RTCTS_B_SYSTEM_CLOCK = 0;
  localparam int RTCTS_B_PIN = 1;
  localparam int RTCTS_B_SLEEP = 2;
  localparam int RTCTS_CAP_W = 4;

  // ==========================================================================
  // reset values
  localparam logic [RTCTS_CAP_W-1:0] RTCTS_CAP_RST = 4'h0;
  localparam logic [7:0] RTCTS_RDATA_RST = 8'h00;

  // ==========================================================================
  // timing
  localparam int RTCTS_CLK_MHZ = 250;
  localparam int RTCTS_BLANK_US = 2000;
  localparam int RTCTS_FAIL_US = 100;
  localparam int RTCTS_BLANK_CYC = RTCTS_BLANK_US * RTCTS_CLK_MHZ;
  localparam int RTCTS_FAIL_CYC = RTCTS_FAIL_US * RTCTS_CLK_MHZ;
  localparam int RTCTS_STEP_TICKS = 16;
  localparam int RTCTS_CNT_W = 20;
  localparam int RTCTS_STEP_W = 8;

  // ==========================================================================
  // state record of the control block
  typedef struct packed {
    logic power;
    logic mcd_en;
    logic fail;
    logic osc_crystal_select;
    logic bias2;
    logic lfo_en;
    logic agc;
    logic autostep;
    logic [RTCTS_CAP_W-1:0] cap_final;
    logic [RTCTS_CAP_W-1:0] cap_applied;
    logic cap_ready;
    logic clk_valid;
    logic system_clock_sel;
    logic pin_route;
    logic sleep_route;
    logic tb_prev;
    logic osc_prev;
    logic tick;
    logic tick_bit1;
    logic blank_done;
    logic [RTCTS_CNT_W-1:0] blank_cnt;
    logic [RTCTS_CNT_W-1:0] stall_cnt;
    logic [RTCTS_STEP_W-1:0] step_cnt;
    logic [7:0] rdata;
  } rtcts_state_t;

endpackage

/* src/rtcts_sync.sv */
// two-stage synchroniser for levels arriving from outside the clock domain.
// assumes the inputs are slow against the system clock.
`timescale 1ns/1ps
module rtcts_sync
  import rtcts_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } rtcts_sync_t;

  rtcts_sync_t st_r;
  rtcts_sync_t st_nxt;

  // ==========================================================================
  // one chain per bit; the first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < WIDTH; i++) begin
      st_nxt.meta[i] = async_i[i];
      st_nxt.stable[i] = st_r.meta[i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.stable;

endmodule

/* src/rtcts_ctrl.sv */
// timebase source control: source selection, tick generation, load
// capacitance stepping, clock-valid gating and the oscillator control bits.
// assumes oscillator pins, internal slow oscillator and amplitude detector
// arrive asynchronously; software drives the plain register port.
`timescale 1ns/1ps

// Overview of operation
// RQ1: timebase independent of system clock, three sources
// RQ2: mode bit one crystal, zero self-oscillate
// RQ3: slow oscillator enable powers and selects it
// RQ4: slow oscillator ticks advance timer bit one
// RQ5: four-bit capacitance code, final code stored
// RQ6: autostep starts smallest, rises to final code
// RQ7: ready flag set when applied reaches final
// RQ8: bias doubling selects 20 or 40 kHz
// RQ9: bias doubling is bit five of control
// RQ10: clock valid forced low without bias doubling
// RQ11: software ignores clock valid with external clock
// RQ12: software follows crystal startup sequence
// RQ13: software keeps gain control off self-oscillating
// RQ14: software uses lowest bias for external clock
// RQ15: slow oscillator and self-oscillator tick at once
// RQ16: timebase routable to system clock and pin
// RQ17: clock valid blanked two ms after power-on
// RQ18: fail flag on stuck oscillator beyond 100 us
// RQ19: autostep raises one code per fixed interval
module rtcts_ctrl
  import rtcts_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES = RTCTS_BLANK_CYC,
  parameter int unsigned FAIL_CYCLES = RTCTS_FAIL_CYC,
  parameter int unsigned STEP_TICKS = RTCTS_STEP_TICKS
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic osc_pin_in_i,
  input wire logic low_freq_osc_i,
  input wire logic osc_amp_ok_i,
  output logic osc_power_enable_o,
  output logic osc_crystal_select_o,
  output logic bias_double_enable_o,
  output logic gain_ctrl_enable_o,
  output logic low_freq_osc_enable_o,
  output logic [RTCTS_CAP_W-1:0] cap_code_o,
  output logic clock_valid_flag_o,
  output logic osc_fail_flag_o,
  output logic tick_o,
  output logic tick_bit1_o,
  output logic system_clock_select_o,
  output logic pin_route_o,
  output logic sleep_route_o
);

  localparam logic [RTCTS_CNT_W-1:0] BLANK_LAST = RTCTS_CNT_W'(BLANK_CYCLES - 1);
  localparam logic [RTCTS_CNT_W-1:0] FAIL_LIMIT = RTCTS_CNT_W'(FAIL_CYCLES);
  localparam logic [RTCTS_STEP_W-1:0] STEP_LAST = RTCTS_STEP_W'(STEP_TICKS - 1);

  rtcts_state_t st_r;
  rtcts_state_t st_nxt;
  logic [2:0] pins_s;
  logic osc_s;
  logic lfo_s;
  logic amp_s;
  logic tb_sel;
  logic osc_rise;
  logic stall_hit;
  logic wr_ctrl;
  logic wr_octl;
  logic wr_ocfg;
  logic wr_route;

  // ==========================================================================
  // pin synchronisers
  rtcts_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i({osc_amp_ok_i, low_freq_osc_i, osc_pin_in_i}),
    .sync_o(pins_s)
  );

  assign osc_s = pins_s[0];
  assign lfo_s = pins_s[1];
  assign amp_s = pins_s[2];

  // ==========================================================================
  // source selection; slow oscillator wins over the oscillator circuit
  always_comb begin
    if (st_r.lfo_en) begin
      tb_sel = lfo_s; // [RQ3] [RQ1]
    end else if (st_r.power) begin
      tb_sel = osc_s; // [RQ1] [RQ2]
    end else begin
      tb_sel = 1'b0;
    end
  end

  assign osc_rise = osc_s & ~st_r.osc_prev;
  assign stall_hit = (st_r.stall_cnt == FAIL_LIMIT);
  assign wr_ctrl = wr_i && (addr_i == RTCTS_ADDR_CTRL);
  assign wr_octl = wr_i && (addr_i == RTCTS_ADDR_OSC_CTL);
  assign wr_ocfg = wr_i && (addr_i == RTCTS_ADDR_OSC_CFG);
  assign wr_route = wr_i && (addr_i == RTCTS_ADDR_ROUTE);

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // register writes
    if (wr_ctrl) begin
      st_nxt.power = wdata_i[RTCTS_B_POWER];
      st_nxt.mcd_en = wdata_i[RTCTS_B_MCD_EN];
      st_nxt.fail = wdata_i[RTCTS_B_FAIL];
    end
    if (wr_octl) begin
      st_nxt.osc_crystal_select = wdata_i[RTCTS_B_OSC_CRYSTAL_SELECT]; // [RQ2]
      st_nxt.bias2 = wdata_i[RTCTS_B_BIAS2]; // [RQ9] [RQ8]
      st_nxt.lfo_en = wdata_i[RTCTS_B_LFO_EN]; // [RQ3]
      st_nxt.agc = wdata_i[RTCTS_B_AGC];
    end
    if (wr_ocfg) begin
      st_nxt.autostep = wdata_i[RTCTS_B_AUTOSTEP];
      st_nxt.cap_final = wdata_i[RTCTS_CAP_W-1:0]; // [RQ5]
    end
    if (wr_route) begin
      st_nxt.system_clock_sel = wdata_i[RTCTS_B_SYSTEM_CLOCK]; // [RQ16]
      st_nxt.pin_route = wdata_i[RTCTS_B_PIN]; // [RQ16]
      st_nxt.sleep_route = wdata_i[RTCTS_B_SLEEP]; // [RQ16]
    end

    // ticks: no start-up wait for any source
    st_nxt.tb_prev = tb_sel;
    st_nxt.osc_prev = osc_s;
    st_nxt.tick = tb_sel & ~st_r.tb_prev; // [RQ15]
    st_nxt.tick_bit1 = tb_sel & ~st_r.tb_prev & st_r.lfo_en; // [RQ4]

    // blanking after the oscillator circuit powers up
    if (!st_r.power) begin
      st_nxt.blank_cnt = '0;
      st_nxt.blank_done = 1'b0;
    end else if (st_r.blank_cnt == BLANK_LAST) begin
      st_nxt.blank_done = 1'b1; // [RQ17]
    end else begin
      st_nxt.blank_cnt = st_r.blank_cnt + 1'b1;
    end
    // amplitude detector only speaks while bias doubling is on
    st_nxt.clk_valid = st_r.bias2 & st_r.blank_done & amp_s; // [RQ10] [RQ17]

    // missing-clock detector; hardware set wins over a clearing write
    if (!(st_r.mcd_en && st_r.power) || (osc_s != st_r.osc_prev)) begin
      st_nxt.stall_cnt = '0;
    end else if (!stall_hit) begin
      st_nxt.stall_cnt = st_r.stall_cnt + 1'b1;
    end
    if (st_r.mcd_en && st_r.power && stall_hit) begin
      st_nxt.fail = 1'b1; // [RQ18]
    end

    // load capacitance stepping
    if (!st_r.autostep) begin
      st_nxt.cap_applied = st_r.cap_final;
      st_nxt.step_cnt = '0;
    end else if (!st_r.power) begin
      st_nxt.cap_applied = RTCTS_CAP_RST; // [RQ6]
      st_nxt.step_cnt = '0;
    end else if (st_r.cap_applied < st_r.cap_final) begin
      if (osc_rise) begin
        if (st_r.step_cnt == STEP_LAST) begin
          st_nxt.step_cnt = '0;
          st_nxt.cap_applied = st_r.cap_applied + 1'b1; // [RQ6] [RQ19]
        end else begin
          st_nxt.step_cnt = st_r.step_cnt + 1'b1; // [RQ19]
        end
      end
    end else begin
      // final lowered below the applied code: follow at once
      st_nxt.cap_applied = st_r.cap_final;
      st_nxt.step_cnt = '0;
    end
    st_nxt.cap_ready = (st_r.cap_applied == st_r.cap_final); // [RQ7]

    // read port, data only in the cycle after the strobe
    st_nxt.rdata = RTCTS_RDATA_RST;
    if (rd_i) begin
      case (addr_i)
        RTCTS_ADDR_CTRL: begin
          st_nxt.rdata[RTCTS_B_POWER] = st_r.power;
          st_nxt.rdata[RTCTS_B_MCD_EN] = st_r.mcd_en;
          st_nxt.rdata[RTCTS_B_FAIL] = st_r.fail;
        end
        RTCTS_ADDR_OSC_CTL: begin
          st_nxt.rdata[RTCTS_B_OSC_CRYSTAL_SELECT] = st_r.osc_crystal_select;
          st_nxt.rdata[RTCTS_B_BIAS2] = st_r.bias2;
          st_nxt.rdata[RTCTS_B_CLOCK_VALID_FLAG] = st_r.clk_valid;
          st_nxt.rdata[RTCTS_B_LFO_EN] = st_r.lfo_en;
          st_nxt.rdata[RTCTS_B_AGC] = st_r.agc;
        end
        RTCTS_ADDR_OSC_CFG: begin
          st_nxt.rdata[RTCTS_B_AUTOSTEP] = st_r.autostep;
          st_nxt.rdata[RTCTS_B_CAP_RDY] = st_r.cap_ready;
          st_nxt.rdata[RTCTS_CAP_W-1:0] = st_r.cap_final;
        end
        RTCTS_ADDR_ROUTE: begin
          st_nxt.rdata[RTCTS_B_SYSTEM_CLOCK] = st_r.system_clock_sel;
          st_nxt.rdata[RTCTS_B_PIN] = st_r.pin_route;
          st_nxt.rdata[RTCTS_B_SLEEP] = st_r.sleep_route;
        end
        default: begin
          st_nxt.rdata = RTCTS_RDATA_RST;
        end
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign rdata_o = st_r.rdata;
  assign osc_power_enable_o = st_r.power;
  assign osc_crystal_select_o = st_r.osc_crystal_select; // [RQ2]
  assign bias_double_enable_o = st_r.bias2; // [RQ8]
  assign gain_ctrl_enable_o = st_r.agc;
  assign low_freq_osc_enable_o = st_r.lfo_en; // [RQ3]
  assign cap_code_o = st_r.cap_applied; // [RQ5]
  assign clock_valid_flag_o = st_r.clk_valid;
  assign osc_fail_flag_o = st_r.fail;
  assign tick_o = st_r.tick;
  assign tick_bit1_o = st_r.tick_bit1;
  assign system_clock_select_o = st_r.system_clock_sel;
  assign pin_route_o = st_r.pin_route;
  assign sleep_route_o = st_r.sleep_route;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_valid_needs_bias: assert property ( // [RQ10]
    !bias_double_enable_o |=> !clock_valid_flag_o)
    else $error("clock valid high without bias doubling");

  a_valid_blanked: assert property ( // [RQ17]
    $rose(osc_power_enable_o) |-> !clock_valid_flag_o [*8])
    else $error("clock valid inside blanking interval");

  a_mode_write: assert property ( // [RQ2]
    wr_i && addr_i == RTCTS_ADDR_OSC_CTL |=>
      osc_crystal_select_o == $past(wdata_i[RTCTS_B_OSC_CRYSTAL_SELECT]))
    else $error("mode bit not applied");

  a_bias_write: assert property ( // [RQ9]
    wr_i && addr_i == RTCTS_ADDR_OSC_CTL |=>
      bias_double_enable_o == $past(wdata_i[RTCTS_B_BIAS2]))
    else $error("bias doubling bit not applied");

  a_lfo_tick_bit1: assert property ( // [RQ4]
    tick_o |-> tick_bit1_o == $past(low_freq_osc_enable_o))
    else $error("timer advance bit wrong for source");

  a_lfo_immediate: assert property ( // [RQ15]
    low_freq_osc_enable_o && $past(low_freq_osc_enable_o) && st_r.tb_prev == 1'b0
      && lfo_s |=> tick_o)
    else $error("slow oscillator edge gave no tick");

  a_ready_match: assert property ( // [RQ7]
    $rose(st_r.cap_ready) |-> $past(cap_code_o == st_r.cap_final))
    else $error("ready set before final code");

  a_step_by_one: assert property ( // [RQ19]
    st_r.autostep && $past(st_r.autostep) && osc_power_enable_o
      && $past(osc_power_enable_o) && cap_code_o > $past(cap_code_o) |->
      cap_code_o == $past(cap_code_o) + 1'b1)
    else $error("capacitance step larger than one code");

  a_step_start: assert property ( // [RQ6]
    st_r.autostep && !osc_power_enable_o |=> cap_code_o == RTCTS_CAP_RST)
    else $error("stepping does not start at smallest code");

  a_fail_sets: assert property ( // [RQ18]
    st_r.mcd_en && osc_power_enable_o && stall_hit |=> osc_fail_flag_o)
    else $error("stuck oscillator not flagged");

  a_read_once: assert property (
    !rd_i |=> rdata_o == RTCTS_RDATA_RST)
    else $error("read data outside answer cycle");

  // fail is sticky: only a write to the control register may drop it
  a_fail_sticky: assert property ( // [RQ18]
    osc_fail_flag_o && !(wr_i && addr_i == RTCTS_ADDR_CTRL) |=> osc_fail_flag_o)
    else $error("fail flag dropped without a clearing write");

  a_fail_quiet: assert property ( // [RQ18]
    !st_r.mcd_en && !osc_fail_flag_o && !(wr_i && addr_i == RTCTS_ADDR_CTRL) |=>
      !osc_fail_flag_o)
    else $error("fail flag set with detector off");

  a_no_source: assert property ( // [RQ1]
    !low_freq_osc_enable_o && !osc_power_enable_o |=> !tick_o)
    else $error("tick without a timebase source");

  a_lfo_write: assert property ( // [RQ3]
    wr_i && addr_i == RTCTS_ADDR_OSC_CTL |=>
      low_freq_osc_enable_o == $past(wdata_i[RTCTS_B_LFO_EN]))
    else $error("slow oscillator enable not applied");

  a_auto_off: assert property ( // [RQ5]
    !st_r.autostep |=> cap_code_o == $past(st_r.cap_final))
    else $error("final code not applied without stepping");

  // stepping only moves on a pin edge; a lowered final may jump down
  a_step_on_edge: assert property ( // [RQ19]
    st_r.autostep && osc_power_enable_o && !osc_rise |=> cap_code_o <= $past(cap_code_o))
    else $error("capacitance rose without an oscillator edge");

  a_ready_drops: assert property ( // [RQ7]
    cap_code_o != st_r.cap_final |=> !st_r.cap_ready)
    else $error("ready flag while codes differ");

  a_route_write: assert property ( // [RQ16]
    wr_i && addr_i == RTCTS_ADDR_ROUTE |=>
      system_clock_select_o == $past(wdata_i[RTCTS_B_SYSTEM_CLOCK])
      && pin_route_o == $past(wdata_i[RTCTS_B_PIN])
      && sleep_route_o == $past(wdata_i[RTCTS_B_SLEEP]))
    else $error("routing bits not applied");

  c_lfo_tick: cover property (low_freq_osc_enable_o && tick_o);
  c_cap_ready: cover property (st_r.autostep && $rose(st_r.cap_ready));
  c_clock_valid: cover property ($rose(clock_valid_flag_o));
  c_fail: cover property ($rose(osc_fail_flag_o));

endmodule

/* test/rtcts_osc_model.sv */
// pin-side partner: crystal or external clock on the oscillator pin,
// the internal slow oscillator and the amplitude detector.
// assumes power and slow-osc enable come from the control block outputs.
`timescale 1ns/1ps
module rtcts_osc_model #(
  parameter real HALF_NS = 20.3,
  parameter real LFO_HALF_NS = 61.7,
  parameter int AMP_HALVES = 2
) (
  input wire logic power_i,
  input wire logic lfo_en_i,
  input wire logic run_i,
  output logic osc_pin_o,
  output logic lfo_o,
  output logic amp_ok_o
);
  // ==========================================================================
  // oscillator pin and amplitude detector
  int amp_cnt;
  initial begin
    osc_pin_o = 1'b1;
    lfo_o = 1'b0;
    amp_ok_o = 1'b0;
    amp_cnt = 0;
  end
  // pin idles high: weak pull-up while unpowered or stalled
  always #(HALF_NS) begin
    if (power_i && run_i) osc_pin_o = ~osc_pin_o;
    else osc_pin_o = 1'b1;
    amp_cnt = power_i ? amp_cnt + 1 : 0;
    amp_ok_o = power_i && (amp_cnt >= AMP_HALVES);
  end
  // ==========================================================================
  // slow oscillator, runs only while enabled
  always #(LFO_HALF_NS) lfo_o = lfo_en_i ? ~lfo_o : 1'b0;
endmodule

/* test/rtc_timebase_source_control_tb_top.sv */
// testbench for the timebase source control block: register port tasks,
// crystal startup, slow oscillator, fail detect and routing.
// assumes the pin-side model and shortened blanking, fail and step counts.
`timescale 1ns/1ps
module rtc_timebase_source_control_tb_top import rtcts_pkg::*;;
  // ==========================================================================
  // signals
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_r = 8'h00;
  logic [7:0] wdata_r = 8'h00;
  logic wr_r = 1'b0;
  logic rd_r = 1'b0;
  logic run_r = 1'b1;
  logic step_mon = 1'b0;
  logic [7:0] rdata_o;
  logic osc_pin, low_freq_osc, amp_ok, pwr, xsel, bias2, agc, lfo_en, cvalid, fail, tick, tick1;
  logic system_clock_sel, pin_rt, sleep_rt;
  logic [RTCTS_CAP_W-1:0] cap;
  logic [RTCTS_CAP_W-1:0] cap_prev = 4'h0;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2 clk_sys_i = ~clk_sys_i;

  rtcts_ctrl #(.BLANK_CYCLES(20), .FAIL_CYCLES(10), .STEP_TICKS(2)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_r), .wdata_i(wdata_r),
    .wr_i(wr_r), .rd_i(rd_r), .rdata_o(rdata_o), .osc_pin_in_i(osc_pin),
    .low_freq_osc_i(low_freq_osc), .osc_amp_ok_i(amp_ok), .osc_power_enable_o(pwr),
    .osc_crystal_select_o(xsel), .bias_double_enable_o(bias2),
    .gain_ctrl_enable_o(agc), .low_freq_osc_enable_o(lfo_en), .cap_code_o(cap),
    .clock_valid_flag_o(cvalid), .osc_fail_flag_o(fail), .tick_o(tick),
    .tick_bit1_o(tick1), .system_clock_select_o(system_clock_sel), .pin_route_o(pin_rt),
    .sleep_route_o(sleep_rt));

  rtcts_osc_model osc_u (
    .power_i(pwr), .lfo_en_i(lfo_en), .run_i(run_r), .osc_pin_o(osc_pin),
    .lfo_o(low_freq_osc), .amp_ok_o(amp_ok));

  // ==========================================================================
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_r <= 1'b1;
    addr_r <= a;
    wdata_r <= d;
    @(posedge clk_sys_i);
    wr_r <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    rd_r <= 1'b1;
    addr_r <= a;
    @(posedge clk_sys_i);
    rd_r <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask
  task automatic count_ticks(input int n, output int nt, output int nb);
    nt = 0;
    nb = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
      nt += int'(tick === 1'b1);
      nb += int'(tick1 === 1'b1);
    end
  endtask

  // ==========================================================================
  // stepping monitor: the applied code only ever moves up by one
  always @(posedge clk_sys_i) begin
    #1;
    if (step_mon && cap !== cap_prev) check({4'h0, cap}, {4'h0, cap_prev + 4'h1});
    cap_prev = cap;
  end
  // hang guard, run needs well under 3000 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    int nt, nb, i;
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    cycles(1);
    check({pwr, xsel, bias2, agc, lfo_en, cvalid, fail, tick}, 8'h00);
    rd_chk(RTCTS_ADDR_CTRL, 8'h00);
    rd_chk(RTCTS_ADDR_OSC_CTL, 8'h00);
    rd_chk(RTCTS_ADDR_OSC_CFG, 8'h40);
    rd_chk(RTCTS_ADDR_ROUTE, 8'h00);
    wr_reg(8'h44, 8'hff);
    rd_chk(8'h44, 8'h00);
    // crystal startup in software order
    wr_reg(RTCTS_ADDR_OSC_CTL, 8'h70);
    check({5'h00, agc, xsel, bias2}, 8'h03);
    rd_chk(RTCTS_ADDR_OSC_CTL, 8'h60);
    wr_reg(RTCTS_ADDR_OSC_CFG, 8'hc5);
    rd_chk(RTCTS_ADDR_OSC_CFG, 8'h85);
    step_mon = 1'b1;
    wr_reg(RTCTS_ADDR_CTRL, 8'h80);
    check({3'h0, pwr, cap}, 8'h10);
    cycles(14);
    check({7'h00, cvalid}, 8'h00);
    for (i = 0; i < 400 && cvalid !== 1'b1; i++) cycles(1);
    check({7'h00, cvalid}, 8'h01);
    rd_chk(RTCTS_ADDR_OSC_CTL, 8'h70);
    for (i = 0; i < 600 && cap !== 4'h5; i++) cycles(1);
    check({4'h0, cap}, 8'h05);
    cycles(2);
    rd_chk(RTCTS_ADDR_OSC_CFG, 8'hc5);
    step_mon = 1'b0;
    wr_reg(RTCTS_ADDR_OSC_CTL, 8'h44);
    cycles(3);
    check({6'h00, agc, cvalid}, 8'h02);
    wr_reg(RTCTS_ADDR_CTRL, 8'hc0);
    count_ticks(100, nt, nb);
    check({7'h00, 1'(nt >= 8)}, 8'h01);
    check(8'(nb), 8'h00);
    check({7'h00, fail}, 8'h00);
    // stall the pin: detector must trip
    run_r = 1'b0;
    for (i = 0; i < 60 && fail !== 1'b1; i++) cycles(1);
    check({7'h00, fail}, 8'h01);
    rd_chk(RTCTS_ADDR_CTRL, 8'he0);
    run_r = 1'b1;
    // let the pin move again first: a stuck pin would set fail over the clear
    cycles(16);
    wr_reg(RTCTS_ADDR_CTRL, 8'h80);
    rd_chk(RTCTS_ADDR_CTRL, 8'h80);
    // external clock on the pin: lowest bias, gain off, detector as proof
    wr_reg(RTCTS_ADDR_OSC_CTL, 8'h40);
    wr_reg(RTCTS_ADDR_CTRL, 8'hc0);
    cycles(40);
    check({6'h00, cvalid, fail}, 8'h00);
    // self-oscillate with slow oscillator selected, gain kept off
    wr_reg(RTCTS_ADDR_OSC_CTL, 8'h28);
    check({4'h0, agc, bias2, lfo_en, xsel}, 8'h06);
    count_ticks(300, nt, nb);
    check({7'h00, 1'(nt >= 7)}, 8'h01);
    check(8'(nb), 8'(nt));
    wr_reg(RTCTS_ADDR_OSC_CTL, 8'h00);
    check({7'h00, bias2}, 8'h00);
    wr_reg(RTCTS_ADDR_ROUTE, 8'h07);
    check({5'h00, sleep_rt, pin_rt, system_clock_sel}, 8'h07);
    rd_chk(RTCTS_ADDR_ROUTE, 8'h07);
    wr_reg(RTCTS_ADDR_CTRL, 8'h00);
    cycles(2);
    check({3'h0, pwr, cap}, 8'h00);
    conclude();
  end
endmodule
